// File: core/osz_pkg.sv
package osz_pkg;
  // channel geometry
  localparam int unsigned NUM_CHAN = 8;
  localparam int unsigned DATA_W = 10;
  localparam int unsigned FRAME_W = 12;
  // framing bits around every payload word
  localparam logic START_BIT = 1'b1;
  localparam logic STOP_BIT = 1'b0;
  // six ones then six zeros, first bit sent is bit 0
  localparam logic [11:0] SYNC_FRAME = 12'h03f;
  // consecutive high samples of a sync request before the pattern starts
  localparam logic [2:0] SYNC_HOLD_CYCLES = 3'h4;
  // pll lock time in clock periods, and the allowed window
  localparam logic [9:0] LOCK_CYCLES = 10'h1ff;
  localparam logic [9:0] LOCK_MIN = 10'h1fe;
  localparam logic [9:0] LOCK_MAX = 10'h201;
  // self-test select code for all lanes, and pattern seed
  localparam logic [3:0] SEL_ALL = 4'h8;
  localparam logic [6:0] PRBS_SEED = 7'h7f;
  // register byte offsets
  localparam int unsigned ADDR_W = 8;
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_CHAN = 8'h04;
  localparam logic [7:0] REG_STAT = 8'h08;
  // register word field positions
  localparam int unsigned CTRL_DEN_BIT = 0;
  localparam int unsigned CTRL_MASTER_BIT = 1;
  localparam int unsigned CTRL_ACT_BIT = 2;
  localparam int unsigned CTRL_SEL_LSB = 4;
  localparam int unsigned CHAN_SYNC_LSB = 8;
  localparam int unsigned STAT_LOCK_BIT = 1;
  localparam int unsigned STAT_SYNC_LSB = 8;
  localparam int unsigned STAT_BIST_LSB = 16;
  localparam int unsigned STAT_OE_LSB = 24;
  // values after reset
  localparam logic [3:0] SEL_RST = 4'hf;
  localparam logic [7:0] SLEEP_N_RST = 8'hff;
  // bus answers
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // one serial lane: drive enable and the 12-bit word sent this period
  typedef struct packed {
    logic oe;
    logic [11:0] frame;
  } osz_lane_t;

  // software control word
  typedef struct packed {
    logic output_drive_enable;
    logic master_n;
    logic act;
    logic [3:0] sel;
  } osz_ctrl_t;

  // shared pll state
  typedef enum logic [2:0] {
    PLL_OFF = 3'b001,
    PLL_LOCKING = 3'b010,
    PLL_LOCKED = 3'b100
  } osz_pll_t;
endpackage : osz_pkg

// File: core/osz_channel.sv
module osz_channel #(
  parameter logic [6:0] SEED = 7'h7f
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ch_run,
  input wire logic drive_en,
  input wire logic sync_req,
  input wire logic bist_en,
  input wire logic [9:0] par_in,
  output osz_pkg::osz_lane_t lane
);
  logic [2:0] sync_cnt_ff; // consecutive high samples of sync_req
  logic [6:0] prbs_ff; // pattern generator state
  logic [16:0] prbs_nxt; // next state and ten pattern bits
  logic sync_now; // this edge sends the sync pattern
  osz_pkg::osz_lane_t lane_ff;

  // ten prbs7 steps per period, bit 0 produced first
  function automatic logic [16:0] prbs_step(input logic [6:0] s);
    logic [6:0] st;
    logic [9:0] b;
    st = s;
    b = '0;
    for (int i = 0; i < 10; i++) begin
      b[i] = st[6] ^ st[5];
      st = {st[5:0], b[i]};
    end
    return {st, b};
  endfunction : prbs_step

  assign prbs_nxt = prbs_step(prbs_ff);

  always_ff @(posedge aclk) begin
    if (!aresetn || !ch_run || !sync_req) begin
      sync_cnt_ff <= '0;
    end else if (sync_cnt_ff != osz_pkg::SYNC_HOLD_CYCLES) begin
      sync_cnt_ff <= sync_cnt_ff + 3'h1;
    end
  end

  assign sync_now = ch_run && sync_req && (sync_cnt_ff >= (osz_pkg::SYNC_HOLD_CYCLES - 3'h1));

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      prbs_ff <= SEED;
    end else if (bist_en && ch_run) begin
      prbs_ff <= prbs_nxt[16:10];
    end
  end

  // word picked at the rising edge; test over sync over data
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      lane_ff.frame <= '0;
    end else if (bist_en) begin
      lane_ff.frame <= {osz_pkg::STOP_BIT, prbs_nxt[9:0], osz_pkg::START_BIT};
    end else if (sync_now) begin
      lane_ff.frame <= osz_pkg::SYNC_FRAME;
    end else begin
      lane_ff.frame <= {osz_pkg::STOP_BIT, par_in, osz_pkg::START_BIT};
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      lane_ff.oe <= 1'b0;
    end else begin
      lane_ff.oe <= ch_run && drive_en;
    end
  end

  assign lane = lane_ff;

  a_sync_entry: assert property (
    @(posedge aclk) disable iff (!aresetn)
    (ch_run && sync_req && !bist_en)[*4] |=> (lane_ff.frame == osz_pkg::SYNC_FRAME))
    else $error("sync pattern not sent after four request cycles");
  a_data_frame: assert property (
    @(posedge aclk) disable iff (!aresetn)
    (!sync_req && !bist_en) |=>
      (lane_ff.frame == {osz_pkg::STOP_BIT, $past(par_in), osz_pkg::START_BIT}))
    else $error("data word not framed as start, data, stop");
  a_chan_sleep: assert property (
    @(posedge aclk) disable iff (!aresetn)
    !ch_run |=> !lane_ff.oe)
    else $error("sleeping channel still drives");
  a_prbs_word: assert property (
    @(posedge aclk) disable iff (!aresetn)
    (bist_en && ch_run)[*2] |=> (lane_ff.frame[10:1] != $past(lane_ff.frame[10:1], 1))
      && (lane_ff.frame[0] == osz_pkg::START_BIT))
    else $error("self-test word repeated or lost its start bit");
endmodule : osz_channel

// File: core/osz_octal_serializer.sv
module osz_octal_serializer #(
  parameter int unsigned NUM_CHAN = osz_pkg::NUM_CHAN
) (
  input wire logic aclk,
  input wire logic aresetn,
  // axi4-lite slave
  input wire logic [osz_pkg::ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [osz_pkg::ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // device pins
  input wire logic supply_ok,
  input wire logic [NUM_CHAN-1:0] chan_sync_request,
  input wire logic [NUM_CHAN-1:0][9:0] chan_parallel_in,
  output osz_pkg::osz_lane_t [NUM_CHAN-1:0] serial_out_pair
);
  ////////////////////////////////////////////////////////////////////////////
  // elaboration check
  generate
    if (NUM_CHAN < 1 || NUM_CHAN > 8) begin : g_bad_num
      $error("NUM_CHAN must be 1 to 8");
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers, two flops before any use
  logic supply_meta_ff; // first stage, read only by next stage
  logic supply_ok_ff; // usable supply level
  logic [NUM_CHAN-1:0] sync_meta_ff; // first stage of sync pins
  logic [NUM_CHAN-1:0] sync_pin_ff; // usable sync pin levels

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      supply_meta_ff <= 1'b0;
      supply_ok_ff <= 1'b0;
    end else begin
      supply_meta_ff <= supply_ok;
      supply_ok_ff <= supply_meta_ff;
    end
  end

  // receiver lock feedback may arrive here asynchronously
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sync_meta_ff <= '0;
      sync_pin_ff <= '0;
    end else begin
      sync_meta_ff <= chan_sync_request;
      sync_pin_ff <= sync_meta_ff;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // control registers
  osz_pkg::osz_ctrl_t ctrl_ff; // drive enable, master wake, self-test
  logic [NUM_CHAN-1:0] chan_sleep_n_ff; // per-channel wake
  logic [NUM_CHAN-1:0] sync_reg_ff; // software sync requests
  logic [31:0] ctrl_word; // control register as read
  logic [31:0] chan_word; // channel register as read
  logic [31:0] stat_word; // status register as read
  logic [31:0] ctrl_merged; // control word with the write's byte lanes applied
  logic [31:0] chan_merged; // channel word with the write's byte lanes applied

  // write side state
  logic aw_held_ff;
  logic w_held_ff;
  logic [osz_pkg::ADDR_W-1:0] awaddr_ff;
  logic [31:0] wdata_ff;
  logic [3:0] wstrb_ff;
  logic awready_ff;
  logic wready_ff;
  logic bvalid_ff;
  logic [1:0] bresp_ff;
  logic do_write; // both halves present, response slot free
  logic nxt_aw_held;
  logic nxt_w_held;
  logic nxt_bvalid;

  // read side state
  logic arready_ff;
  logic rvalid_ff;
  logic [31:0] rdata_ff;
  logic [1:0] rresp_ff;

  // byte-lane merge of a write
  function automatic logic [31:0] merge(input logic [31:0] old_v, input logic [31:0] new_v,
                                        input logic [3:0] strb);
    logic [31:0] r;
    r = old_v;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        r[i*8 +: 8] = new_v[i*8 +: 8];
      end
    end
    return r;
  endfunction : merge

  ////////////////////////////////////////////////////////////////////////////
  // shared pll and lock sequencing
  osz_pkg::osz_pll_t pll_ff; // pll state
  logic [9:0] lock_cnt_ff; // periods spent locking
  logic awake; // supply good and master not sleeping
  logic pll_locked; // lanes may run

  assign awake = supply_ok_ff && ctrl_ff.master_n;
  assign pll_locked = (pll_ff == osz_pkg::PLL_LOCKED);

  // lock sequence restarts on every wake
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pll_ff <= osz_pkg::PLL_OFF;
      lock_cnt_ff <= '0;
    end else begin
      unique case (pll_ff)
        osz_pkg::PLL_OFF: begin
          // stays off until power and master wake
          lock_cnt_ff <= '0;
          if (awake) begin
            pll_ff <= osz_pkg::PLL_LOCKING;
          end
        end
        osz_pkg::PLL_LOCKING: begin
          lock_cnt_ff <= lock_cnt_ff + 10'h001;
          if (!awake) begin
            pll_ff <= osz_pkg::PLL_OFF;
          end else if (lock_cnt_ff == osz_pkg::LOCK_CYCLES - 10'h001) begin
            pll_ff <= osz_pkg::PLL_LOCKED;
          end
        end
        osz_pkg::PLL_LOCKED: begin
          // sleep or supply loss drops lock at once
          if (!awake) begin
            pll_ff <= osz_pkg::PLL_OFF;
          end
        end
        default: begin
          // illegal code recovers through off
          pll_ff <= osz_pkg::PLL_OFF;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // self-test channel selection
  logic [NUM_CHAN-1:0] bist_mask; // channels sending prbs

  always_comb begin
    bist_mask = '0;
    if (ctrl_ff.act) begin
      if (ctrl_ff.sel == osz_pkg::SEL_ALL) begin
        bist_mask = '1;
      end else if (!ctrl_ff.sel[3] && ({1'b0, ctrl_ff.sel[2:0]} < 4'(NUM_CHAN))) begin
        bist_mask[ctrl_ff.sel[2:0]] = 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // channels
  logic [NUM_CHAN-1:0] ch_run; // per-channel awake and locked
  logic [NUM_CHAN-1:0] ch_sync; // merged sync request
  logic [NUM_CHAN-1:0] ch_sync_mode; // lane currently in sync pattern
  osz_pkg::osz_lane_t [NUM_CHAN-1:0] lanes;

  genvar gc;
  generate
    for (gc = 0; gc < NUM_CHAN; gc++) begin : g_chan
      // channel runs after lock when its own wake is set
      assign ch_run[gc] = pll_locked && chan_sleep_n_ff[gc];
      assign ch_sync[gc] = sync_reg_ff[gc] || sync_pin_ff[gc];
      assign ch_sync_mode[gc] = (lanes[gc].frame == osz_pkg::SYNC_FRAME);
      osz_channel #(
        .SEED(osz_pkg::PRBS_SEED)
      ) u_chan (
        .aclk(aclk),
        .aresetn(aresetn),
        .ch_run(ch_run[gc]),
        .drive_en(ctrl_ff.output_drive_enable),
        .sync_req(ch_sync[gc]),
        .bist_en(bist_mask[gc]),
        .par_in(chan_parallel_in[gc]),
        .lane(lanes[gc])
      );
    end
  endgenerate

  assign serial_out_pair = lanes;

  ////////////////////////////////////////////////////////////////////////////
  // register views
  assign ctrl_word = {24'h000000, ctrl_ff.sel, 1'b0, ctrl_ff.act, ctrl_ff.master_n,
                      ctrl_ff.output_drive_enable};
  assign chan_word = {16'h0000, 8'(sync_reg_ff), 8'(chan_sleep_n_ff)};

  // status shows lock, sync, test and drive per channel
  always_comb begin
    stat_word = '0;
    stat_word[0] = supply_ok_ff;
    stat_word[osz_pkg::STAT_LOCK_BIT] = pll_locked;
    stat_word[osz_pkg::STAT_SYNC_LSB +: 8] = 8'(ch_sync_mode);
    stat_word[osz_pkg::STAT_BIST_LSB +: 8] = 8'(bist_mask);
    for (int i = 0; i < NUM_CHAN; i++) begin
      stat_word[osz_pkg::STAT_OE_LSB + i] = lanes[i].oe;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // write channel: address and data taken in either order
  assign do_write = aw_held_ff && w_held_ff && !bvalid_ff;
  // a function result cannot be bit-selected, so merge into words first
  assign ctrl_merged = merge(ctrl_word, wdata_ff, wstrb_ff);
  assign chan_merged = merge(chan_word, wdata_ff, wstrb_ff);

  always_comb begin
    nxt_aw_held = aw_held_ff;
    nxt_w_held = w_held_ff;
    nxt_bvalid = bvalid_ff;
    if (s_axi_awvalid && awready_ff) begin
      nxt_aw_held = 1'b1;
    end
    if (s_axi_wvalid && wready_ff) begin
      nxt_w_held = 1'b1;
    end
    if (bvalid_ff && s_axi_bready) begin
      nxt_bvalid = 1'b0;
    end
    if (do_write) begin
      nxt_aw_held = 1'b0;
      nxt_w_held = 1'b0;
      nxt_bvalid = 1'b1;
    end
  end

  // capture halves, ready drops while a half is held
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_ff <= 1'b0;
      w_held_ff <= 1'b0;
      awaddr_ff <= '0;
      wdata_ff <= '0;
      wstrb_ff <= '0;
      awready_ff <= 1'b0;
      wready_ff <= 1'b0;
      bvalid_ff <= 1'b0;
    end else begin
      aw_held_ff <= nxt_aw_held;
      w_held_ff <= nxt_w_held;
      bvalid_ff <= nxt_bvalid;
      awready_ff <= !nxt_aw_held && !nxt_bvalid;
      wready_ff <= !nxt_w_held && !nxt_bvalid;
      if (s_axi_awvalid && awready_ff) begin
        awaddr_ff <= s_axi_awaddr;
      end
      if (s_axi_wvalid && wready_ff) begin
        wdata_ff <= s_axi_wdata;
        wstrb_ff <= s_axi_wstrb;
      end
    end
  end

  // register update; status is read-only and ignores writes
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_ff <= '{output_drive_enable: 1'b0, master_n: 1'b1, act: 1'b0, sel: osz_pkg::SEL_RST};
      chan_sleep_n_ff <= NUM_CHAN'(osz_pkg::SLEEP_N_RST);
      sync_reg_ff <= '0;
      bresp_ff <= osz_pkg::RESP_OKAY;
    end else if (do_write) begin
      bresp_ff <= osz_pkg::RESP_OKAY;
      unique case (awaddr_ff)
        osz_pkg::REG_CTRL: begin
          // drive enable only gates outputs; other state is untouched
          ctrl_ff.output_drive_enable <= ctrl_merged[osz_pkg::CTRL_DEN_BIT];
          ctrl_ff.master_n <= ctrl_merged[osz_pkg::CTRL_MASTER_BIT];
          ctrl_ff.act <= ctrl_merged[osz_pkg::CTRL_ACT_BIT];
          ctrl_ff.sel <= ctrl_merged[osz_pkg::CTRL_SEL_LSB +: 4];
        end
        osz_pkg::REG_CHAN: begin
          chan_sleep_n_ff <= NUM_CHAN'(chan_merged);
          sync_reg_ff <= NUM_CHAN'(chan_merged >> osz_pkg::CHAN_SYNC_LSB);
        end
        osz_pkg::REG_STAT: begin
          bresp_ff <= osz_pkg::RESP_OKAY;
        end
        default: begin
          // unmapped address
          bresp_ff <= osz_pkg::RESP_SLVERR;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // read channel: one read at a time, data registered
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready_ff <= 1'b0;
      rvalid_ff <= 1'b0;
      rdata_ff <= '0;
      rresp_ff <= osz_pkg::RESP_OKAY;
    end else if (s_axi_arvalid && arready_ff) begin
      arready_ff <= 1'b0;
      rvalid_ff <= 1'b1;
      rresp_ff <= osz_pkg::RESP_OKAY;
      unique case (s_axi_araddr)
        osz_pkg::REG_CTRL: rdata_ff <= ctrl_word;
        osz_pkg::REG_CHAN: rdata_ff <= chan_word;
        osz_pkg::REG_STAT: rdata_ff <= stat_word;
        default: begin
          rdata_ff <= '0;
          rresp_ff <= osz_pkg::RESP_SLVERR;
        end
      endcase
    end else if (rvalid_ff && s_axi_rready) begin
      rvalid_ff <= 1'b0;
      arready_ff <= 1'b1;
    end else if (!rvalid_ff) begin
      arready_ff <= 1'b1;
    end
  end

  assign s_axi_awready = awready_ff;
  assign s_axi_wready = wready_ff;
  assign s_axi_bvalid = bvalid_ff;
  assign s_axi_bresp = bresp_ff;
  assign s_axi_arready = arready_ff;
  assign s_axi_rvalid = rvalid_ff;
  assign s_axi_rdata = rdata_ff;
  assign s_axi_rresp = rresp_ff;

  ////////////////////////////////////////////////////////////////////////////
  // checks
  logic [9:0] awake_age_ff; // periods since wake, saturating

  always_ff @(posedge aclk) begin
    if (!aresetn || !awake) begin
      awake_age_ff <= '0;
    end else if (awake_age_ff != 10'h3ff) begin
      awake_age_ff <= awake_age_ff + 10'h001;
    end
  end

  a_lock_window: assert property (
    @(posedge aclk) disable iff (!aresetn)
    $rose(pll_locked) |-> (awake_age_ff >= osz_pkg::LOCK_MIN && awake_age_ff <= osz_pkg::LOCK_MAX))
    else $error("pll lock outside allowed window");
  a_den_tristate: assert property (
    @(posedge aclk) disable iff (!aresetn)
    !ctrl_ff.output_drive_enable |=> (stat_word[osz_pkg::STAT_OE_LSB +: 8] == 8'h00))
    else $error("lane driven while drive enable low");
  a_sleep_tristate: assert property (
    @(posedge aclk) disable iff (!aresetn)
    !ctrl_ff.master_n |=> !pll_locked ##1 (stat_word[osz_pkg::STAT_OE_LSB +: 8] == 8'h00))
    else $error("master sleep left pll running or lanes driven");
  a_supply_gate: assert property (
    @(posedge aclk) disable iff (!aresetn)
    !supply_ok_ff |=> (pll_ff == osz_pkg::PLL_OFF))
    else $error("pll left off state without good supply");
  a_bist_single: assert property (
    @(posedge aclk) disable iff (!aresetn)
    (ctrl_ff.act && !ctrl_ff.sel[3]) |-> ($countones(bist_mask) <= 1))
    else $error("single-channel test selected several lanes");
  a_bist_none: assert property (
    @(posedge aclk) disable iff (!aresetn)
    (ctrl_ff.sel > osz_pkg::SEL_ALL || !ctrl_ff.act) |-> (bist_mask == '0))
    else $error("self-test active for a no-test select");
  a_data_gate: assert property (
    @(posedge aclk) disable iff (!aresetn)
    (ctrl_ff.output_drive_enable && ch_run[0]) |=> lanes[0].oe)
    else $error("enabled running lane not driven");
endmodule : osz_octal_serializer

// File: tb/osz_rx_model.sv
// far-side receiver: decodes one lane the way a locking deserializer would
module osz_rx_model (
  input wire logic aclk,
  input wire osz_pkg::osz_lane_t lane,
  output logic [9:0] rx_data,
  output logic rx_framed
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [9:0] held_ff;  // last word seen
  always_ff @(posedge aclk) begin
    held_ff <= rx_data;
  end
  // payload after start bit
  // an undriven line must not look like the last word
  always_comb begin
    rx_data = lane.oe ? lane.frame[10:1] : ~held_ff;
  end
  assign rx_framed = lane.oe & (lane.frame[0] === 1'b1) & (lane.frame[11] === 1'b0);
endmodule : osz_rx_model

// File: tb/octal_serializer_10to1_tb_top.sv
module octal_serializer_10to1_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [7:0] awaddr, araddr, sync_pin, m;
  logic awvalid, wvalid, bready, arvalid, rready, supply_ok;
  logic [31:0] wdata, seed, rd_d;
  logic [1:0] rd_r, bresp, rresp;
  logic [7:0][9:0] par, rx_data;
  logic [7:0] rx_framed;
  logic awready, wready, bvalid, arready, rvalid;
  logic [31:0] rdata;
  osz_pkg::osz_lane_t [7:0] lanes;
  int miscompares, comparisons, diffs, cnt;
  // bench acts as the clock source
  always #50 aclk = ~aclk;
  osz_octal_serializer uut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .supply_ok(supply_ok), .chan_sync_request(sync_pin), .chan_parallel_in(par),
    .serial_out_pair(lanes));
  for (genvar n = 0; n < 8; n++) begin : g_rx
    osz_rx_model rx (.aclk(aclk), .lane(lanes[n]), .rx_data(rx_data[n]),
      .rx_framed(rx_framed[n]));
  end
  ////////////////////////////////////////////////////////////////
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : xs
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      miscompares++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
    logic pa, pw;
    pa = 1'b1;
    pw = 1'b1;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    while (pa | pw) begin
      @(posedge aclk);
      if (pa && awready === 1'b1) begin
        pa = 1'b0;
        awvalid <= 1'b0;
      end
      if (pw && wready === 1'b1) begin
        pw = 1'b0;
        wvalid <= 1'b0;
      end
    end
    bready <= 1'b1;
    do @(posedge aclk); while (bvalid !== 1'b1);
    bready <= 1'b0;
    chk({30'h0, bresp}, {30'h0, r});
  endtask : wr
  task automatic rd(input logic [7:0] a);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    do @(posedge aclk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    rready <= 1'b1;
    do @(posedge aclk); while (rvalid !== 1'b1);
    rready <= 1'b0;
    rd_d = rdata;
    rd_r = rresp;
  endtask : rd
  // one period: new random words in, last period's words checked on every driven lane outside self-test and sync
  task automatic step(input logic [7:0] oe_m, input logic [7:0] syn_m, input logic [7:0] t_m);
    logic [7:0][9:0] prev;
    prev = par;
    @(posedge aclk);
    par <= 80'({xs(), xs(), xs()});
    #1;
    for (int n = 0; n < 8; n++) begin
      if (!oe_m[n]) chk({31'h0, lanes[n].oe}, 32'h0);
      else if (t_m[n]) begin
        chk({31'h0, rx_framed[n]}, 32'h1);
        if (rx_data[n] !== prev[n]) diffs++;
      end else chk({19'h0, lanes[n]}, {19'h0, 1'b1, syn_m[n] ? osz_pkg::SYNC_FRAME :
        {osz_pkg::STOP_BIT, prev[n], osz_pkg::START_BIT}});
    end
  endtask : step
  task automatic wait_lane();
    cnt = 0;
    do begin
      @(posedge aclk);
      cnt++;
    end while (lanes[0].oe !== 1'b1 && cnt < 1000);
  endtask : wait_lane
  task automatic complete_run();
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : complete_run
  ////////////////////////////////////////////////////////////////
  // hang guard, far beyond the two lock waits and the test sweep
  initial begin
    repeat (20000) @(posedge aclk);
    miscompares++;
    complete_run();
  end
  initial begin
    {awaddr, araddr, sync_pin, awvalid, wvalid, bready, arvalid, rready} = '0;
    {supply_ok, wdata, par, diffs, miscompares, comparisons} = '0;
    seed = 32'h42d08a3d;
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    rd(8'h00);
    chk(rd_d, 32'h0000_00f2);
    rd(8'h04);
    chk(rd_d, 32'h0000_00ff);
    // no supply: nothing locks, nothing drives
    repeat (600) @(posedge aclk);
    rd(8'h08);
    chk(rd_d, 32'h0);
    rd(8'h10);
    chk(rd_d, 32'h0);
    chk({30'h0, rd_r}, {30'h0, osz_pkg::RESP_SLVERR});
    wr(8'h0c, 32'h1, osz_pkg::RESP_SLVERR);
    supply_ok <= 1'b1;
    wr(8'h00, 32'hf3, osz_pkg::RESP_OKAY);
    wait_lane();
    repeat (20) step(8'hff, 8'h0, 8'h0);
    // short request of three periods must not start the pattern
    @(posedge aclk);
    sync_pin <= 8'h08;
    repeat (3) @(posedge aclk);
    sync_pin <= 8'h00;
    repeat (8) step(8'hff, 8'h0, 8'h0);
    // pin pulse stands in for receiver lock feedback
    sync_pin <= 8'h08;
    cnt = 0;
    do begin
      @(posedge aclk);
      cnt++;
    end while (lanes[3].frame !== osz_pkg::SYNC_FRAME && cnt < 20);
    chk({31'h0, cnt >= 4 && cnt <= 8}, 32'h1);
    repeat (6) step(8'hff, 8'h08, 8'h0);
    sync_pin <= 8'h00;
    repeat (4) @(posedge aclk);
    repeat (6) step(8'hff, 8'h0, 8'h0);
    m = 8'(xs());
    wr(8'h04, {24'h0, m}, osz_pkg::RESP_OKAY);
    repeat (3) step(m, 8'h0, 8'h0);
    wr(8'h04, 32'hff, osz_pkg::RESP_OKAY);
    wr(8'h00, 32'hf2, osz_pkg::RESP_OKAY);
    repeat (3) step(8'h0, 8'h0, 8'h0);
    wr(8'h00, 32'hf3, osz_pkg::RESP_OKAY);
    repeat (3) step(8'hff, 8'h0, 8'h0);
    for (int s = 0; s < 16; s++) begin
      m = (s < 8) ? 8'(1 << s) : ((s == 8) ? 8'hff : 8'h00);
      wr(8'h00, {24'h0, s[3:0], 4'h7}, osz_pkg::RESP_OKAY);
      rd(8'h08);
      chk({24'h0, rd_d[23:16]}, {24'h0, m});
      repeat (12) @(posedge aclk);
      diffs = 0;
      repeat (4) step(8'hff, 8'h0, m);
      chk({31'h0, (diffs > 0) == (m != 8'h0)}, 32'h1);
    end
    wr(8'h00, 32'hf1, osz_pkg::RESP_OKAY);
    repeat (3) step(8'h0, 8'h0, 8'h0);
    wr(8'h00, 32'hf3, osz_pkg::RESP_OKAY);
    wait_lane();
    chk({31'h0, cnt >= 507 && cnt <= 514}, 32'h1);
    complete_run();
  end
endmodule : octal_serializer_10to1_tb_top
